// >>> core/ethernet_tx_encapsulator.v
// MII transmit frames encapsulated into a LAPS or GFP byte stream
// How it works
// - scramble_off skips scrambling, core header still balanced
// - check_field_corrupt sends a wrong check field
// - check_field_omit drops the four check bytes
// - address/port byte sent unless its inhibit set
// - control/type low byte sent; software programs GFP
// - LAPS underrun inserts rate adaptation byte
// - same byte is GFP type high byte
// - LAPS readout starts at start level reached
// - GFP readout waits for a whole frame
// - address_insert_off takes address from payload
// - control_insert_off takes control from payload
// - two access point bytes inserted unless inhibited
// - abort sequence on underrun without rate adaptation unless abort_off
// - rate_adapt_off plus abort_off corrupts check field
// - core_header_off applies after state reset, idles excepted
// - independent type and extension check corruption
// - ext_header_off drops whole extension header
// - type_header_insert_off takes type bytes from payload
// - good frames counted at frame end
// - counters read-only, wrap, top byte zero
// - odd nibble frames counted as alignment errors
// - frames with error signal counted
// - sticky event flags cleared by writing one
// - mask bits gate events from summary interrupt
`include "encap_tx_defs.vh"
module ethernet_tx_encapsulator (
  input wire mclk_in,
  input wire nrst_in,
  input wire soft_reset_in,
  input wire encap_gfp_in,
  input wire mii_clk_in,
  input wire [3:0] mii_txd_in,
  input wire mii_tx_en_in,
  input wire mii_tx_er_in,
  input wire [8:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [7:0] reg_rdata_out,
  output wire [7:0] out_data_out,
  output wire out_last_out,
  output wire out_valid_out,
  input wire out_ready_in,
  output reg summary_interrupt_out
);
  localparam S_WAIT = 3'd0;
  localparam S_HDR = 3'd1;
  localparam S_PAY = 3'd2;
  localparam S_FCS = 3'd3;
  localparam S_ABORT = 3'd4;
  localparam S_DRAIN = 3'd5;
  localparam S_IDLE = 3'd6;

  function [31:0] crc32_b;
    input [31:0] c;
    input [7:0] d;
    integer i;
    reg [31:0] x;
    begin
      x = c;
      for (i = 7; i >= 0; i = i - 1)
        x = {x[30:0], 1'b0} ^ ((x[31] ^ d[i]) ? `CRC32_POLY : 32'h0);
      crc32_b = x;
    end
  endfunction

  function [15:0] hec16;
    input [15:0] d;
    integer i;
    reg [15:0] x;
    begin
      x = 16'h0000;
      for (i = 15; i >= 0; i = i - 1)
        x = {x[14:0], 1'b0} ^ ((x[15] ^ d[i]) ? `CRC16_POLY : 16'h0);
      hec16 = x;
    end
  endfunction

  function [50:0] scr_b;
    input [42:0] s;
    input [7:0] d;
    integer i;
    reg [42:0] x;
    reg [7:0] o;
    begin
      x = s;
      o = 8'h00;
      for (i = 7; i >= 0; i = i - 1) begin
        o[i] = d[i] ^ x[42];
        x = {x[41:0], o[i]};
      end
      scr_b = {x, o};
    end
  endfunction

  function hdr_on;
    input [3:0] i;
    input gfp;
    input [4:0] lc;
    input [4:0] gc;
    input core_off;
    begin
      if (gfp) begin
        case (i[3:2])
          2'd0: hdr_on = !core_off;
          2'd1: hdr_on = !gc[`B_TYPE_OFF];
          2'd2: hdr_on = !gc[`B_EXT_OFF];
          default: hdr_on = 1'b0;
        endcase
      end else begin
        case (i)
          4'd0: hdr_on = !lc[`B_ADR_OFF];
          4'd1: hdr_on = !lc[`B_CNT_OFF];
          4'd2: hdr_on = !lc[`B_SAPI_OFF];
          4'd3: hdr_on = !lc[`B_SAPI_OFF];
          default: hdr_on = 1'b0;
        endcase
      end
    end
  endfunction

  function [3:0] hdr_next;
    input [3:0] from;
    input gfp;
    input [4:0] lc;
    input [4:0] gc;
    input core_off;
    integer i;
    reg [3:0] n;
    begin
      n = `HDR_DONE;
      for (i = 11; i >= 0; i = i - 1)
        if (i >= from && hdr_on(i[3:0], gfp, lc, gc, core_off))
          n = i[3:0];
      hdr_next = n;
    end
  endfunction

  reg rst_meta_ff, rst_sync_ff;
  wire rst_n = rst_sync_ff;
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // Registers
  reg [2:0] ctrl_ff;
  reg [7:0] address_port_byte_ff, control_type_low_byte_ff;
  reg [7:0] rate_adapt_type_high_byte_ff;
  reg [10:0] thr_ff;
  reg [4:0] laps_ctl_ff, gfp_ctl_ff;
  reg [7:0] access_point_low_spare_byte_ff, access_point_high_byte_ff;
  reg [23:0] good_frame_count_ff, align_cnt_ff, error_signal_count_ff;
  reg [15:0] ovf_cnt_ff, urun_cnt_ff;
  reg [3:0] ev_ff, mask_ff;
  reg core_off_eff_ff;

  // MII sampling: clock and pins through two flops
  reg [6:0] mii_s1_ff, mii_s2_ff;
  reg mclk_prev_ff;
  wire m_clk = mii_s2_ff[6];
  wire m_en = mii_s2_ff[5];
  wire m_er = mii_s2_ff[4];
  wire [3:0] m_txd = mii_s2_ff[3:0];
  wire m_fall = mclk_prev_ff & ~m_clk;

  reg in_frame_ff, nib_odd_ff, er_seen_ff, ovf_ff, have_byte_ff;
  reg good_pend_ff;
  reg [3:0] lo_nib_ff;
  reg [8:0] mem [0:`FIFO_DEPTH-1];
  reg [`FIFO_AW-1:0] wp_ff, rp_ff;
  reg [11:0] f_cnt_ff;
  reg [7:0] frames_ff;
  wire f_empty = (f_cnt_ff == 12'h000);
  wire f_full = (f_cnt_ff == `FIFO_DEPTH);
  wire [8:0] f_rd = mem[rp_ff];
  wire nib_w = m_fall & m_en & nib_odd_ff & ~ovf_ff;
  wire w_en = nib_w & ~f_full;
  wire ovf_evt = nib_w & f_full;
  wire w_end = m_fall & ~m_en & in_frame_ff;
  wire w_mark = w_end & have_byte_ff & ~f_empty;
  wire align_evt = w_end & nib_odd_ff & ~ovf_ff & ~er_seen_ff;
  wire er_evt = w_end & er_seen_ff & ~ovf_ff;

  // Reader state
  reg [2:0] st_ff;
  reg [3:0] idx_ff;
  reg [1:0] sub_ff;
  reg gfp_ff, urun_ff, ucorr_ff;
  reg [31:0] crc_ff;
  reg [42:0] scr_ff;
  reg [15:0] len_ff, cur_len_ff;

  reg g_valid, g_crc, g_scr, g_pop, g_last;
  reg [7:0] g_byte;
  reg [15:0] pli, hec;
  reg [31:0] fcs_w;
  wire [31:0] dc_bal = `DC_BAL;
  reg [8:0] ob0_ff, ob1_ff;
  reg [1:0] ob_cnt_ff;
  wire buf_ready = (ob_cnt_ff != 2'd2);
  wire g_fire = g_valid & buf_ready;
  wire pop_fire = g_pop & (buf_ready | ~g_valid);
  wire [50:0] scr_res = scr_b(scr_ff, g_byte);
  wire scr_use = g_scr & ~ctrl_ff[`B_SCR_OFF];
  wire [7:0] o_byte = scr_use ? scr_res[7:0] : g_byte;
  wire urun_now = (st_ff == S_PAY) & f_empty & in_frame_ff;
  wire ra_on = ~gfp_ff & ~laps_ctl_ff[`B_RA_OFF];
  wire urun_evt = urun_now & ~urun_ff;
  wire [3:0] hdr_nx = hdr_next(idx_ff + 4'd1, gfp_ff, laps_ctl_ff,
    gfp_ctl_ff, core_off_eff_ff);
  wire [3:0] hdr_first = hdr_next(4'd0, encap_gfp_in, laps_ctl_ff,
    gfp_ctl_ff, core_off_eff_ff);
  wire pay_end = (pop_fire & f_rd[8]) |
    ((st_ff == S_PAY) & f_empty & ~in_frame_ff);

  // Header and trailer bytes
  always @* begin
    pli = cur_len_ff;
    if (!gfp_ctl_ff[`B_TYPE_OFF])
      pli = pli + 16'd4;
    if (!gfp_ctl_ff[`B_EXT_OFF])
      pli = pli + 16'd4;
    if (!ctrl_ff[`B_CHK_OMIT])
      pli = pli + 16'd4;
    hec = 16'h0000;
    g_byte = 8'h00;
    case (idx_ff[3:2])
      2'd0: hec = hec16(pli);
      2'd1: hec = hec16({rate_adapt_type_high_byte_ff,
        control_type_low_byte_ff}) ^
        {15'h0000, gfp_ctl_ff[`B_TYPE_CORR]};
      default: hec = hec16({address_port_byte_ff,
        access_point_low_spare_byte_ff}) ^
        {15'h0000, gfp_ctl_ff[`B_EXT_CORR]};
    endcase
    fcs_w = ~crc_ff ^ {31'h0, ctrl_ff[`B_CHK_CORR] | ucorr_ff};
    g_valid = 1'b0;
    g_crc = 1'b0;
    g_scr = 1'b0;
    g_pop = 1'b0;
    g_last = 1'b0;
    case (st_ff)
      S_HDR: begin
        g_valid = 1'b1;
        g_crc = ~gfp_ff;
        g_scr = ~gfp_ff | (idx_ff > 4'd3);
        if (!gfp_ff) begin
          case (idx_ff[1:0])
            2'd0: g_byte = address_port_byte_ff;
            2'd1: g_byte = control_type_low_byte_ff;
            2'd2: g_byte = access_point_high_byte_ff;
            default: g_byte = access_point_low_spare_byte_ff;
          endcase
        end else if (idx_ff < 4'd4) begin
          case (idx_ff[1:0])
            2'd0: g_byte = pli[15:8] ^ dc_bal[31:24];
            2'd1: g_byte = pli[7:0] ^ dc_bal[23:16];
            2'd2: g_byte = hec[15:8] ^ dc_bal[15:8];
            default: g_byte = hec[7:0] ^ dc_bal[7:0];
          endcase
        end else begin
          case (idx_ff[1:0])
            2'd0: g_byte = idx_ff[3] ? address_port_byte_ff :
              rate_adapt_type_high_byte_ff;
            2'd1: g_byte = idx_ff[3] ? access_point_low_spare_byte_ff :
              control_type_low_byte_ff;
            2'd2: g_byte = hec[15:8];
            default: g_byte = hec[7:0];
          endcase
        end
      end
      S_PAY: begin
        if (!f_empty) begin
          g_valid = 1'b1;
          g_byte = f_rd[7:0];
          g_crc = 1'b1;
          g_scr = 1'b1;
          g_pop = 1'b1;
          g_last = f_rd[8] & ctrl_ff[`B_CHK_OMIT];
        end else if (in_frame_ff & ra_on) begin
          g_valid = 1'b1;
          g_byte = rate_adapt_type_high_byte_ff;
          g_scr = 1'b1;
        end
      end
      S_FCS: begin
        g_valid = 1'b1;
        g_scr = 1'b1;
        g_byte = fcs_w[{~sub_ff, 3'b000} +: 8];
        g_last = (sub_ff == 2'd3);
      end
      S_ABORT: begin
        g_valid = 1'b1;
        g_byte = sub_ff[0] ? `ABORT_B1 : `ABORT_B0;
        g_last = sub_ff[0];
      end
      S_DRAIN: g_pop = ~f_empty;
      S_IDLE: begin
        g_valid = 1'b1;
        g_byte = dc_bal[{~sub_ff, 3'b000} +: 8];
        g_last = (sub_ff == 2'd3);
      end
      default: g_valid = 1'b0;
    endcase
  end

  // MII receive side and transmit FIFO
  always @(posedge mclk_in) begin
    if (w_en)
      mem[wp_ff] <= {1'b0, m_txd, lo_nib_ff};
    if (w_mark)
      mem[wp_ff - 11'd1][8] <= 1'b1;
  end

  always @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      mii_s1_ff <= 7'h00;
      mii_s2_ff <= 7'h00;
      mclk_prev_ff <= 1'b0;
      in_frame_ff <= 1'b0;
      nib_odd_ff <= 1'b0;
      er_seen_ff <= 1'b0;
      ovf_ff <= 1'b0;
      have_byte_ff <= 1'b0;
      lo_nib_ff <= 4'h0;
      wp_ff <= 11'h000;
      len_ff <= 16'h0000;
    end else begin
      mii_s1_ff <= {mii_clk_in, mii_tx_en_in, mii_tx_er_in, mii_txd_in};
      mii_s2_ff <= mii_s1_ff;
      mclk_prev_ff <= m_clk;
      if (m_fall & m_en) begin
        in_frame_ff <= 1'b1;
        nib_odd_ff <= ~nib_odd_ff;
        if (!in_frame_ff) begin
          er_seen_ff <= m_er;
          ovf_ff <= 1'b0;
          have_byte_ff <= 1'b0;
          len_ff <= 16'h0000;
        end else if (m_er) begin
          er_seen_ff <= 1'b1;
        end
        if (!nib_odd_ff)
          lo_nib_ff <= m_txd;
        if (ovf_evt)
          ovf_ff <= 1'b1;
        if (w_en) begin
          wp_ff <= wp_ff + 11'd1;
          have_byte_ff <= 1'b1;
          len_ff <= len_ff + 16'd1;
        end
      end else if (w_end) begin
        in_frame_ff <= 1'b0;
        nib_odd_ff <= 1'b0;
      end
    end
  end

  // Encapsulation sequencer
  always @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= S_WAIT;
      idx_ff <= 4'h0;
      sub_ff <= 2'd0;
      gfp_ff <= 1'b0;
      urun_ff <= 1'b0;
      ucorr_ff <= 1'b0;
      crc_ff <= 32'hFFFFFFFF;
      scr_ff <= 43'h0;
      cur_len_ff <= 16'h0000;
      rp_ff <= 11'h000;
      f_cnt_ff <= 12'h000;
      frames_ff <= 8'h00;
      good_pend_ff <= 1'b0;
      good_frame_count_ff <= 24'h000000;
      align_cnt_ff <= 24'h000000;
      error_signal_count_ff <= 24'h000000;
      ovf_cnt_ff <= 16'h0000;
      urun_cnt_ff <= 16'h0000;
    end else begin
      if (g_fire & g_crc)
        crc_ff <= crc32_b(crc_ff, g_byte);
      if (g_fire & scr_use)
        scr_ff <= scr_res[50:8];
      if (pop_fire)
        rp_ff <= rp_ff + 11'd1;
      f_cnt_ff <= f_cnt_ff + {11'h000, w_en} - {11'h000, pop_fire};
      frames_ff <= frames_ff + {7'h00, w_mark} -
        {7'h00, pop_fire & f_rd[8]};
      if (w_end)
        good_pend_ff <= ~ovf_ff & ~er_seen_ff & ~nib_odd_ff;
      if (align_evt)
        align_cnt_ff <= align_cnt_ff + 24'd1;
      if (er_evt)
        error_signal_count_ff <= error_signal_count_ff + 24'd1;
      if (ovf_evt)
        ovf_cnt_ff <= ovf_cnt_ff + 16'd1;
      if (urun_evt) begin
        urun_cnt_ff <= urun_cnt_ff + 16'd1;
        urun_ff <= 1'b1;
      end
      case (st_ff)
        S_WAIT: begin
          crc_ff <= 32'hFFFFFFFF;
          urun_ff <= 1'b0;
          ucorr_ff <= 1'b0;
          sub_ff <= 2'd0;
          gfp_ff <= encap_gfp_in;
          cur_len_ff <= len_ff;
          idx_ff <= hdr_first;
          if (encap_gfp_in ? (frames_ff != 8'h00) :
              (frames_ff != 8'h00 || f_cnt_ff >= {1'b0, thr_ff}))
            st_ff <= (hdr_first == `HDR_DONE) ? S_PAY : S_HDR;
          else if (encap_gfp_in)
            st_ff <= S_IDLE;
        end
        S_HDR: if (g_fire) begin
          idx_ff <= hdr_nx;
          if (hdr_nx == `HDR_DONE)
            st_ff <= S_PAY;
        end
        S_PAY: begin
          if (pay_end) begin
            if (ctrl_ff[`B_CHK_OMIT]) begin
              st_ff <= S_WAIT;
              if (good_pend_ff & ~urun_ff)
                good_frame_count_ff <= good_frame_count_ff + 24'd1;
              good_pend_ff <= 1'b0;
            end else begin
              st_ff <= S_FCS;
            end
          end else if (urun_now & ~ra_on) begin
            if (!laps_ctl_ff[`B_ABORT_OFF])
              st_ff <= S_ABORT;
            else
              ucorr_ff <= 1'b1;
          end
        end
        S_FCS: if (g_fire) begin
          sub_ff <= sub_ff + 2'd1;
          if (sub_ff == 2'd3) begin
            st_ff <= S_WAIT;
            if (good_pend_ff & ~urun_ff)
              good_frame_count_ff <= good_frame_count_ff + 24'd1;
            good_pend_ff <= 1'b0;
          end
        end
        S_ABORT: if (g_fire) begin
          sub_ff <= sub_ff + 2'd1;
          if (sub_ff[0])
            st_ff <= S_DRAIN;
        end
        S_DRAIN: if ((pop_fire & f_rd[8]) | (f_empty & ~in_frame_ff)) begin
          st_ff <= S_WAIT;
          good_pend_ff <= 1'b0;
        end
        S_IDLE: if (g_fire) begin
          sub_ff <= sub_ff + 2'd1;
          if (sub_ff == 2'd3)
            st_ff <= S_WAIT;
        end
        default: st_ff <= S_WAIT;
      endcase
      if (soft_reset_in) begin
        st_ff <= S_WAIT;
        good_frame_count_ff <= 24'h000000;
        align_cnt_ff <= 24'h000000;
        error_signal_count_ff <= 24'h000000;
        ovf_cnt_ff <= 16'h0000;
        urun_cnt_ff <= 16'h0000;
      end
    end
  end

  // Two-entry output buffer
  assign out_valid_out = (ob_cnt_ff != 2'd0);
  assign out_data_out = ob0_ff[7:0];
  assign out_last_out = ob0_ff[8];
  wire ob_pop = out_valid_out & out_ready_in;
  always @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      ob0_ff <= 9'h000;
      ob1_ff <= 9'h000;
      ob_cnt_ff <= 2'd0;
    end else begin
      ob_cnt_ff <= ob_cnt_ff + {1'b0, g_fire} - {1'b0, ob_pop};
      if (ob_pop)
        ob0_ff <= (g_fire && ob_cnt_ff == 2'd1) ? {g_last, o_byte} : ob1_ff;
      else if (g_fire && ob_cnt_ff == 2'd0)
        ob0_ff <= {g_last, o_byte};
      if (g_fire && (ob_cnt_ff == 2'd2 || (ob_cnt_ff == 2'd1 && !ob_pop)))
        ob1_ff <= {g_last, o_byte};
    end
  end

  // Register port
  always @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= `R_CTRL;
      address_port_byte_ff <= `R_ADDR_PORT;
      control_type_low_byte_ff <= `R_CTL_TYPE_L;
      rate_adapt_type_high_byte_ff <= `R_RA_TYPE_H;
      thr_ff <= `R_THR;
      laps_ctl_ff <= `R_HDR_CTL;
      gfp_ctl_ff <= `R_HDR_CTL;
      access_point_low_spare_byte_ff <= `R_SAPI_LO;
      access_point_high_byte_ff <= `R_SAPI_HI;
      ev_ff <= 4'h0;
      mask_ff <= `R_MASK;
      core_off_eff_ff <= 1'b0;
      reg_rdata_out <= 8'h00;
      summary_interrupt_out <= 1'b0;
    end else begin
      if (soft_reset_in)
        core_off_eff_ff <= gfp_ctl_ff[`B_CORE_OFF];
      ev_ff <= (ev_ff & ~((reg_wr_in && reg_addr_in == `A_EVENT) ?
        reg_wdata_in[3:0] : 4'h0)) |
        {urun_evt, ovf_evt, er_evt, align_evt};
      summary_interrupt_out <= |(ev_ff & ~mask_ff);
      if (reg_wr_in) begin
        case (reg_addr_in)
          `A_CTRL: ctrl_ff <= reg_wdata_in[2:0];
          `A_ADDR_PORT: address_port_byte_ff <= reg_wdata_in;
          `A_CTL_TYPE_L: control_type_low_byte_ff <= reg_wdata_in;
          `A_RA_TYPE_H: rate_adapt_type_high_byte_ff <= reg_wdata_in;
          `A_THR_LO: thr_ff[7:0] <= reg_wdata_in;
          `A_THR_HI: thr_ff[10:8] <= reg_wdata_in[2:0];
          `A_LAPS_CTL: laps_ctl_ff <= reg_wdata_in[4:0];
          `A_GFP_CTL: gfp_ctl_ff <= reg_wdata_in[4:0];
          `A_SAPI_LO: access_point_low_spare_byte_ff <= reg_wdata_in;
          `A_SAPI_HI: access_point_high_byte_ff <= reg_wdata_in;
          `A_MASK: mask_ff <= reg_wdata_in[3:0];
          default: mask_ff <= mask_ff;
        endcase
      end
      if (reg_rd_in) begin
        case (reg_addr_in)
          `A_CTRL: reg_rdata_out <= {5'h00, ctrl_ff};
          `A_ADDR_PORT: reg_rdata_out <= address_port_byte_ff;
          `A_CTL_TYPE_L: reg_rdata_out <= control_type_low_byte_ff;
          `A_RA_TYPE_H: reg_rdata_out <= rate_adapt_type_high_byte_ff;
          `A_THR_LO: reg_rdata_out <= thr_ff[7:0];
          `A_THR_HI: reg_rdata_out <= {5'h00, thr_ff[10:8]};
          `A_LAPS_CTL: reg_rdata_out <= {3'h0, laps_ctl_ff};
          `A_GFP_CTL: reg_rdata_out <= {3'h0, gfp_ctl_ff};
          `A_SAPI_LO: reg_rdata_out <= access_point_low_spare_byte_ff;
          `A_SAPI_HI: reg_rdata_out <= access_point_high_byte_ff;
          `A_GOOD_CNT: reg_rdata_out <= good_frame_count_ff[7:0];
          `A_GOOD_CNT + 9'd1: reg_rdata_out <= good_frame_count_ff[15:8];
          `A_GOOD_CNT + 9'd2: reg_rdata_out <= good_frame_count_ff[23:16];
          `A_ALIGN_CNT: reg_rdata_out <= align_cnt_ff[7:0];
          `A_ALIGN_CNT + 9'd1: reg_rdata_out <= align_cnt_ff[15:8];
          `A_ALIGN_CNT + 9'd2: reg_rdata_out <= align_cnt_ff[23:16];
          `A_ER_CNT: reg_rdata_out <= error_signal_count_ff[7:0];
          `A_ER_CNT + 9'd1: reg_rdata_out <= error_signal_count_ff[15:8];
          `A_ER_CNT + 9'd2: reg_rdata_out <= error_signal_count_ff[23:16];
          `A_OVF_CNT: reg_rdata_out <= ovf_cnt_ff[7:0];
          `A_OVF_CNT + 9'd1: reg_rdata_out <= ovf_cnt_ff[15:8];
          `A_URUN_CNT: reg_rdata_out <= urun_cnt_ff[7:0];
          `A_URUN_CNT + 9'd1: reg_rdata_out <= urun_cnt_ff[15:8];
          `A_EVENT: reg_rdata_out <= {4'h0, ev_ff};
          `A_MASK: reg_rdata_out <= {4'h0, mask_ff};
          default: reg_rdata_out <= 8'h00;
        endcase
      end
    end
  end
endmodule

// >>> pkg/encap_tx_defs.vh
// Register map, reset values, field positions and constants of the encapsulator
`ifndef ENCAP_TX_DEFS_VH
`define ENCAP_TX_DEFS_VH
`define A_CTRL 9'h180
`define A_ADDR_PORT 9'h181
`define A_CTL_TYPE_L 9'h182
`define A_RA_TYPE_H 9'h183
`define A_THR_LO 9'h184
`define A_THR_HI 9'h185
`define A_LAPS_CTL 9'h186
`define A_GFP_CTL 9'h187
`define A_SAPI_LO 9'h188
`define A_SAPI_HI 9'h189
`define A_GOOD_CNT 9'h18C
`define A_ALIGN_CNT 9'h190
`define A_ER_CNT 9'h194
`define A_OVF_CNT 9'h198
`define A_URUN_CNT 9'h19C
`define A_EVENT 9'h1A0
`define A_MASK 9'h1A1
`define R_CTRL 3'h0
`define R_ADDR_PORT 8'h04
`define R_CTL_TYPE_L 8'h03
`define R_RA_TYPE_H 8'hDD
`define R_THR 11'h288
`define R_HDR_CTL 5'h00
`define R_SAPI_LO 8'h01
`define R_SAPI_HI 8'hFE
`define R_MASK 4'hF
`define B_SCR_OFF 2
`define B_CHK_CORR 1
`define B_CHK_OMIT 0
`define B_ADR_OFF 4
`define B_CNT_OFF 3
`define B_SAPI_OFF 2
`define B_ABORT_OFF 1
`define B_RA_OFF 0
`define B_CORE_OFF 4
`define B_EXT_CORR 3
`define B_EXT_OFF 2
`define B_TYPE_CORR 1
`define B_TYPE_OFF 0
`define FIFO_AW 11
`define FIFO_DEPTH 12'h800
`define HDR_DONE 4'hC
`define DC_BAL 32'hB6AB31E0
`define CRC32_POLY 32'h04C11DB7
`define CRC16_POLY 16'h1021
`define ABORT_B0 8'h7D
`define ABORT_B1 8'h7E
`endif

// >>> verif/ethernet_tx_encapsulator_properties.sv
// Checker for the encapsulator's register port and output stream
module ethernet_tx_encapsulator_properties (
  input wire mclk_in,
  input wire nrst_in,
  input wire [8:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [7:0] reg_rdata_out,
  input wire [7:0] out_data_out,
  input wire out_last_out,
  input wire out_valid_out,
  input wire out_ready_in,
  input wire summary_interrupt_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  logic mask_wr_ff;
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in)
      mask_wr_ff <= 1'b0;
    else if (reg_wr_in && reg_addr_in == 9'h1A1)
      mask_wr_ff <= 1'b1;
  end
  a_stall_holds_byte:
    assert property (out_valid_out && !out_ready_in |=> out_valid_out
      && $stable(out_data_out) && $stable(out_last_out))
    else $error("output byte changed while stalled");
  a_rdata_holds:
    assert property (!reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data changed without a read");
  a_masked_quiet:
    assert property (!mask_wr_ff |-> !summary_interrupt_out)
    else $error("summary raised while all masked");
  a_fixed_zero:
    assert property (reg_rd_in && reg_addr_in inside {9'h18F, 9'h193,
      9'h197} |=> reg_rdata_out == 8'h00)
    else $error("counter top byte not zero");
  a_ctl_reserved:
    assert property (reg_rd_in && reg_addr_in inside {9'h180, 9'h185}
      |=> reg_rdata_out[7:3] == 5'h00)
    else $error("reserved control bits set");
  a_hdr_reserved:
    assert property (reg_rd_in && reg_addr_in inside {9'h186, 9'h187}
      |=> reg_rdata_out[7:5] == 3'h0)
    else $error("reserved header bits set");
  a_event_reserved:
    assert property (reg_rd_in && reg_addr_in inside {9'h1A0, 9'h1A1}
      |=> reg_rdata_out[7:4] == 4'h0)
    else $error("reserved event bits set");
  a_addr_readback:
    assert property (reg_wr_in && reg_addr_in == 9'h181 ##1 !reg_wr_in
      ##1 reg_rd_in && !reg_wr_in && reg_addr_in == 9'h181 |=>
      reg_rdata_out == $past(reg_wdata_in, 3))
    else $error("address byte readback wrong");
  c_frame_end: cover property (out_valid_out && out_ready_in && out_last_out);
  c_summary: cover property ($rose(summary_interrupt_out));
  c_stall: cover property (out_valid_out && !out_ready_in);
endmodule
bind ethernet_tx_encapsulator ethernet_tx_encapsulator_properties chk (
  .mclk_in(mclk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .out_data_out(out_data_out), .out_last_out(out_last_out),
  .out_valid_out(out_valid_out), .out_ready_in(out_ready_in),
  .summary_interrupt_out(summary_interrupt_out));

// >>> verif/mii_source_model.sv
// MII transmit source standing in for the MAC
module mii_source_model (
  output logic mii_clk_out,
  output logic [3:0] txd_out,
  output logic tx_en_out,
  output logic tx_er_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    mii_clk_out = 1'b0;
    txd_out = 4'hA;
    tx_en_out = 1'b0;
    tx_er_out = 1'b0;
  end
  always #62.5 mii_clk_out = ~mii_clk_out;
  // Bytes 0x30 upward, low nibble first
  task automatic send(input int n, input bit er, input bit odd);
    logic [7:0] b;
    for (int i = 0; i < 2 * n + odd; i++) begin
      b = 8'h30 + 8'(i / 2);
      @(posedge mii_clk_out);
      tx_en_out <= 1'b1;
      txd_out <= i[0] ? b[7:4] : b[3:0];
      tx_er_out <= er && i == 3;
    end
    @(posedge mii_clk_out);
    tx_en_out <= 1'b0;
    tx_er_out <= 1'b0;
    txd_out <= ~txd_out;
    repeat (3) @(posedge mii_clk_out);
  endtask
endmodule

// >>> verif/tb_ethernet_tx_encapsulator.sv
// Self-checking bench for the encapsulator
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb_ethernet_tx_encapsulator;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in = 0, nrst_in = 0, soft_reset_in = 0, out_ready_in = 0;
  logic reg_wr_in = 0, reg_rd_in = 0, gfp = 0;
  logic [8:0] reg_addr_in = 0;
  logic [7:0] reg_wdata_in = 0, f;
  wire mii_clk, mii_en, mii_er, out_last_out, out_valid_out, irq;
  wire [3:0] mii_txd;
  wire [7:0] reg_rdata_out, out_data_out;
  int miscompares = 0, n_checks = 0, lasts = 0, cyc = 0;
  logic [7:0] got[$];
  logic [8:0] ra[14] = '{9'h180, 9'h181, 9'h182, 9'h183, 9'h184, 9'h185,
    9'h186, 9'h187, 9'h188, 9'h189, 9'h18C, 9'h18F, 9'h1A1, 9'h1FF};
  logic [7:0] rv[14] = '{8'h00, 8'h04, 8'h03, 8'hDD, 8'h88, 8'h02, 8'h00,
    8'h00, 8'h01, 8'hFE, 8'h00, 8'h00, 8'h0F, 8'h00};
  always #5 mclk_in = ~mclk_in;
  always @(negedge mclk_in) begin
    cyc++;
    out_ready_in <= cyc[1:0] != 2'h0;
  end
  always @(posedge mclk_in) if (out_valid_out && out_ready_in) begin
    got.push_back(out_data_out);
    lasts += out_last_out;
  end
  mii_source_model src (.mii_clk_out(mii_clk), .txd_out(mii_txd),
    .tx_en_out(mii_en), .tx_er_out(mii_er));
  ethernet_tx_encapsulator dut (.mclk_in(mclk_in), .nrst_in(nrst_in),
    .soft_reset_in(soft_reset_in), .encap_gfp_in(gfp),
    .mii_clk_in(mii_clk), .mii_txd_in(mii_txd), .mii_tx_en_in(mii_en),
    .mii_tx_er_in(mii_er), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .out_data_out(out_data_out), .out_last_out(out_last_out),
    .out_valid_out(out_valid_out), .out_ready_in(out_ready_in),
    .summary_interrupt_out(irq));
  task wr(input logic [8:0] a, input logic [7:0] d);
    @(negedge mclk_in);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    @(negedge mclk_in);
    reg_wr_in = 1'b0;
  endtask
  task rd(input logic [8:0] a, input logic [7:0] e);
    @(negedge mclk_in);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    @(negedge mclk_in);
    reg_rd_in = 1'b0;
    `CHK(reg_rdata_out, e)
  endtask
  task frame(input int n, input bit er, input bit odd, input int outn);
    int l0;
    got.delete();
    l0 = lasts;
    src.send(n, er, odd);
    for (int k = 0; k < 800 && lasts == l0; k++) @(negedge mclk_in);
    `CHK(lasts - l0, 1)
    if (outn >= 0) `CHK(got.size(), outn)
  endtask
  task t_ra;
    wr(9'h180, 8'h04);
    wr(9'h184, 8'h04);
    wr(9'h185, 8'h00);
    frame(16, 0, 0, -1);
    `CHK(got[8], 8'hDD)
    rd(9'h19C, 8'h01);
    rd(9'h18C, 8'h00);
  endtask
  task t_gfp;
    int l0;
    gfp = 1'b1;
    l0 = lasts + 2;
    for (int k = 0; k < 200 && lasts < l0; k++) @(negedge mclk_in);
    `CHK({got[$-3], got[$-2], got[$-1], got[$]}, 32'hB6AB31E0)
    gfp = 1'b0;
  endtask
  task t_regs;
    for (int i = 0; i < 14; i++) rd(ra[i], rv[i]);
    wr(9'h183, 8'h10);
    rd(9'h183, 8'h10);
    wr(9'h183, 8'hDD);
    wr(9'h18C, 8'h55);
    rd(9'h18C, 8'h00);
    wr(9'h181, 8'h5A);
    rd(9'h181, 8'h5A);
    wr(9'h181, 8'h04);
  endtask
  task t_laps;
    wr(9'h180, 8'h04);
    frame(16, 0, 0, 24);
    `CHK({got[0], got[1], got[2], got[3]}, 32'h0403FE01)
    for (int j = 0; j < 16; j++) `CHK(got[4 + j], 8'h30 + j)
    f = got[23];
    wr(9'h180, 8'h06);
    frame(16, 0, 0, 24);
    `CHK(got[23], f ^ 8'h01)
    rd(9'h18C, 8'h02);
  endtask
  task t_bare;
    wr(9'h180, 8'h05);
    wr(9'h186, 8'h1C);
    frame(16, 0, 0, 16);
    for (int j = 0; j < 16; j++) `CHK(got[j], 8'h30 + j)
    wr(9'h186, 8'h00);
  endtask
  task t_errs;
    frame(16, 0, 1, -1);
    rd(9'h190, 8'h01);
    frame(16, 1, 0, -1);
    rd(9'h194, 8'h01);
    rd(9'h18C, 8'h03);
    rd(9'h1A0, 8'h03);
    `CHK(irq, 1'b0)
    wr(9'h1A1, 8'h00);
    @(negedge mclk_in);
    `CHK(irq, 1'b1)
    wr(9'h1A0, 8'h03);
    @(negedge mclk_in);
    `CHK(irq, 1'b0)
    rd(9'h1A0, 8'h00);
    @(negedge mclk_in);
    soft_reset_in = 1'b1;
    @(negedge mclk_in);
    soft_reset_in = 1'b0;
    rd(9'h18C, 8'h00);
  endtask
  task end_sim;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #300us;
    miscompares++;
    end_sim;
  end
  initial begin
    repeat (4) @(negedge mclk_in);
    nrst_in = 1'b1;
    repeat (3) @(negedge mclk_in);
    t_regs;
    t_laps;
    t_bare;
    t_errs;
    t_ra;
    t_gfp;
    end_sim;
  end
endmodule
